// ==== design/spc_channel.sv ====
// One hardware sprite channel: registers, arming, coincidence, shifter.
//
// Summary of operation
// - Control word bits 15..8 give the low eight vertical stop bits.
// - Control bit 7 attaches an odd sprite to its even partner.
// - Control bit 6 is vertical start bit ten, bit 5 stop bit ten.
// - Control bits 4, 3, 0 add 70, 35 and 140 ns start steps.
// - Control bit 2 is vertical start bit nine, bit 1 stop bit nine.
// - Position and control words accept writes at any time.
// - A control word write disarms the sprite.
// - A write to the low image buffer arms the sprite.
// - At coincidence buffers load shifters, shifted out MSB first.
// - Armed sprite starts when beam equals horizontal start.
// - Legacy pixel is one bitplane pixel lores, two otherwise.
// - Low buffer gives colour LSB, high buffer the weight-2 bit; when attached, weights 4 and 8.
// - Four pixel resolutions: legacy, 140, 70 and 35 ns.
// - Sprite width is 16, 32 or 64 pixels per line.
// - Attachment works in every resolution, 35 ns included.
// - Colour index sits in a selectable 16-entry bank of 256.
// - Position word gives vertical start low bits and start 10..3.
// - Scan-double option drops start bit 10 from the match.
`timescale 1ns/1ps
module spc_channel
    import spc_pkg::*;
#(
    parameter bit IS_ODD = 1'b1,
    parameter int MAX_W  = 64
) (
    input  wire logic        clock_in,
    input  wire logic        reset_n_in,
    input  wire logic [8:0]  addr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [15:0] rdata_out,
    input  wire logic [10:0] hpos_in,
    input  wire logic [10:0] vpos_in,
    input  wire logic        tick_in,
    input  wire logic        high_resolution_mode_in,
    input  wire logic        super_high_resolution_mode_in,
    input  wire logic [1:0]  partner_pair_in,
    output logic      [1:0]  pixel_pair_out,
    output logic      [7:0]  pixel_index_out,
    output logic             pixel_valid_out,
    output logic             attach_out,
    output logic             scan_double_out
);
    // ------------------------------------------------------------
    // Types and storage
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_ARMED = 3'b010,
        ST_SHIFT = 3'b100
    } spc_state_t;

    spc_state_t       state;
    spc_state_t       next_state;
    logic [15:0]      pos;
    logic [15:0]      ctl;
    logic [15:0]      cfg;
    logic [MAX_W-1:0] buf_lo;
    logic [MAX_W-1:0] buf_hi;
    logic [MAX_W-1:0] shift_lo;
    logic [MAX_W-1:0] shift_hi;
    logic [2:0]       sub_cnt;
    logic [6:0]       pix_left;

    function automatic logic hit(input logic [8:0] a,
                                 input logic [8:0] ofs);
        hit = (a == ofs);
    endfunction

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    wire        wr_pos = wr_in && hit(addr_in, OFS_POS);
    wire        wr_ctl = wr_in && hit(addr_in, OFS_CTL);
    wire        wr_lo  = wr_in && hit(addr_in, OFS_BUF_LO);
    wire        wr_hi  = wr_in && hit(addr_in, OFS_BUF_HI);
    wire        wr_cfg = wr_in && hit(addr_in, OFS_CFG);
    wire [10:0] vstart = {1'b0, ctl[CTL_VSTART_B10],
                          ctl[CTL_VSTART_B9],
                          pos[POS_VSTART_LSB +: 8]};
    wire [10:0] vstop  = {1'b0, ctl[CTL_VSTOP_B10],
                          ctl[CTL_VSTOP_B9],
                          ctl[CTL_VSTOP_LSB +: 8]};
    wire [10:0] hstart = {pos[7:0], ctl[CTL_H140],
                          ctl[CTL_H70], ctl[CTL_H35]};
    wire        scan2  = cfg[CFG_SCAN2];
    wire        h_low  = (hpos_in[9:0] == hstart[9:0]);
    wire        h_top  = (hpos_in[10] == hstart[10]);
    wire        h_match = h_low && (scan2 || h_top);
    wire        in_lines = (vpos_in >= vstart)
                        && (vpos_in < vstop);
    wire        attached = IS_ODD && ctl[CTL_ATTACH];
    wire [1:0]  res_sel = cfg[CFG_RES_LSB +: 2];
    wire [1:0]  wid_sel = cfg[CFG_WIDTH_LSB +: 2];
    wire [3:0]  bank    = cfg[CFG_BANK_LSB +: 4];
    wire        start   = (state == ST_ARMED) && tick_in
                        && h_match && in_lines;

    // Pixel length in 35 ns steps.
    logic [2:0] pix_ticks;
    always_comb begin
        unique case (res_sel)
            RES_LEGACY: pix_ticks = super_high_resolution_mode_in
                                    ? TICKS_70 : TICKS_140;
            RES_140:    pix_ticks = TICKS_140;
            RES_70:     pix_ticks = TICKS_70;
            RES_35:     pix_ticks = TICKS_35;
        endcase
    end

    // Line width in pixels; the newest words sit at the bottom.
    logic [6:0] width_px;
    always_comb begin
        unique case (wid_sel)
            WID_16:  width_px = 7'd16;
            WID_32:  width_px = 7'd32;
            default: width_px = 7'(MAX_W);
        endcase
    end
    wire [6:0]       align   = 7'(MAX_W) - width_px;
    wire [MAX_W-1:0] load_lo = buf_lo << align;
    wire [MAX_W-1:0] load_hi = buf_hi << align;
    wire             last_sub = (sub_cnt == pix_ticks - 3'd1);
    wire             step     = (state == ST_SHIFT) && tick_in && last_sub;
    wire [1:0]       pair_now = {shift_hi[MAX_W-1],
                                 shift_lo[MAX_W-1]};
    wire [3:0]       col_now  = attached ? {pair_now, partner_pair_in}
                                         : {2'b00, pair_now};
    wire             showing  = (state == ST_SHIFT);
    wire [2:0]       st_bits  = state;
    wire [15:0]      rd_mux   = hit(addr_in, OFS_CFG) ? cfg
                              : hit(addr_in, OFS_STATUS)
                                ? {12'h000, attached, st_bits}
                              : 16'h0000;

    // ------------------------------------------------------------
    // Arming state machine
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE:  if (wr_lo) begin
                next_state = ST_ARMED;
            end
            ST_ARMED: if (start) begin
                next_state = ST_SHIFT;
            end
            ST_SHIFT: if (step && pix_left == 7'd1) begin
                next_state = ST_ARMED;
            end
            default:  next_state = ST_IDLE;
        endcase
        if (wr_ctl) begin
            next_state = ST_IDLE;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            pos    <= RST_WORD;
            ctl    <= RST_WORD;
            cfg    <= RST_WORD;
            buf_lo <= RST_BUF;
            buf_hi <= RST_BUF;
        end else begin
            if (wr_pos) begin
                pos <= wdata_in;
            end
            if (wr_ctl) begin
                ctl <= wdata_in;
            end
            if (wr_cfg) begin
                cfg <= wdata_in;
            end
            if (wr_lo) begin
                buf_lo <= {buf_lo[MAX_W-17:0], wdata_in};
            end
            if (wr_hi) begin
                buf_hi <= {buf_hi[MAX_W-17:0], wdata_in};
            end
        end
    end

    // ------------------------------------------------------------
    // Shifter
    // ------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            shift_lo <= RST_BUF;
            shift_hi <= RST_BUF;
            sub_cnt  <= 3'd0;
            pix_left <= 7'd0;
        end else if (start) begin
            shift_lo <= load_lo;
            shift_hi <= load_hi;
            sub_cnt  <= 3'd0;
            pix_left <= width_px;
        end else if (showing && tick_in) begin
            sub_cnt <= last_sub ? 3'd0 : sub_cnt + 3'd1;
            if (last_sub) begin
                shift_lo <= shift_lo << 1;
                shift_hi <= shift_hi << 1;
                pix_left <= pix_left - 7'd1;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            pixel_pair_out  <= 2'b00;
            pixel_index_out <= 8'h00;
            pixel_valid_out <= 1'b0;
            attach_out      <= 1'b0;
            scan_double_out <= 1'b0;
            rdata_out       <= 16'h0000;
        end else begin
            pixel_pair_out  <= showing ? pair_now : 2'b00;
            pixel_index_out <= {bank, col_now};
            pixel_valid_out <= showing && (col_now != 4'h0);
            attach_out      <= attached;
            scan_double_out <= scan2 && hstart[10];
            rdata_out       <= rd_in ? rd_mux : 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);

    // A control write in the start cycle disarms, so it is left out here.
    sequence s_start;
        start && !wr_ctl;
    endsequence
    sequence s_loaded;
        state == ST_SHIFT && shift_lo == $past(load_lo);
    endsequence

    chk_ctl_disarm: assert property (wr_ctl |=> state == ST_IDLE)
        else $error("control write did not disarm");
    chk_lo_arm: assert property (
        wr_lo && !wr_ctl && state == ST_IDLE |=> state == ST_ARMED)
        else $error("low buffer write did not arm");
    chk_start_load: assert property (
        s_start |=> s_loaded)
        else $error("coincidence did not load shifter");
    chk_lines_gate: assert property (
        state == ST_ARMED && !in_lines && !wr_ctl
        |=> state == ST_ARMED)
        else $error("sprite started outside its lines");
    chk_pair_out: assert property (
        showing |=> pixel_pair_out == $past(pair_now))
        else $error("pixel pair not from shifter tops");
    chk_attach_idx: assert property (
        attached |=> pixel_index_out[1:0] == $past(partner_pair_in))
        else $error("attached index lost partner bits");
    chk_hold_pixel: assert property (
        showing && !tick_in && !wr_ctl
        |=> $stable(shift_lo) && $stable(shift_hi))
        else $error("shifter moved without a tick");
    chk_scan_out: assert property (
        scan2 && hstart[10] && $stable(cfg) && $stable(pos)
        |=> scan_double_out)
        else $error("scan double enable not shown");
    chk_bank_idx: assert property (
        ##1 pixel_index_out[7:4] == $past(bank))
        else $error("colour bank not applied");
    chk_idle_dark: assert property (
        !showing |=> !pixel_valid_out && pixel_pair_out == 2'b00)
        else $error("pixel shown while not shifting");
    chk_width_end: assert property (
        step && pix_left == 7'h01 && !wr_ctl |=> state == ST_ARMED)
        else $error("sprite did not end after its width");
    chk_sub_hold: assert property (
        showing && tick_in && !last_sub && !wr_ctl
        |=> $stable(shift_lo) && $stable(shift_hi))
        else $error("shifter moved inside a pixel");
endmodule

// ==== pkg/spc_pkg.sv ====
// Constants shared by the sprite channel design.
package spc_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [8:0] OFS_POS    = 9'h140;
    localparam logic [8:0] OFS_CTL    = 9'h142;
    localparam logic [8:0] OFS_BUF_LO = 9'h144;
    localparam logic [8:0] OFS_BUF_HI = 9'h146;
    localparam logic [8:0] OFS_CFG    = 9'h148;
    localparam logic [8:0] OFS_STATUS = 9'h14A;
    // ------------------------------------------------------------
    // Control and position word fields
    // ------------------------------------------------------------
    localparam int CTL_VSTOP_LSB  = 8;
    localparam int CTL_ATTACH     = 7;
    localparam int CTL_VSTART_B10 = 6;
    localparam int CTL_VSTOP_B10  = 5;
    localparam int CTL_H70        = 4;
    localparam int CTL_H35        = 3;
    localparam int CTL_VSTART_B9  = 2;
    localparam int CTL_VSTOP_B9   = 1;
    localparam int CTL_H140       = 0;
    localparam int POS_VSTART_LSB = 8;
    // ------------------------------------------------------------
    // Configuration word fields
    // ------------------------------------------------------------
    localparam int CFG_RES_LSB   = 0;
    localparam int CFG_WIDTH_LSB = 2;
    localparam int CFG_SCAN2     = 4;
    localparam int CFG_BANK_LSB  = 8;
    localparam logic [1:0] RES_LEGACY = 2'h0;
    localparam logic [1:0] RES_140    = 2'h1;
    localparam logic [1:0] RES_70     = 2'h2;
    localparam logic [1:0] RES_35     = 2'h3;
    localparam logic [1:0] WID_16     = 2'h0;
    localparam logic [1:0] WID_32     = 2'h1;
    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [63:0] RST_BUF  = 64'h0000_0000_0000_0000;
    localparam int STEP_NS   = 35;
    localparam int PIX140_NS = 140;
    localparam int PIX70_NS  = 70;
    localparam logic [2:0] TICKS_140 = 3'(PIX140_NS / STEP_NS);
    localparam logic [2:0] TICKS_70  = 3'(PIX70_NS / STEP_NS);
    localparam logic [2:0] TICKS_35  = 3'(STEP_NS / STEP_NS);
endpackage

// ==== bench/spc_beam_model.sv ====
// Beam position and pixel step source standing in for the display timing.
`timescale 1ns/1ps
module spc_beam_model #(
    parameter int HMAX = 160,
    parameter int VMAX = 6
) (
    input  wire logic        clock_in,
    input  wire logic        reset_n_in,
    output logic      [10:0] hpos_out,
    output logic      [10:0] vpos_out,
    output logic             tick_out
);
    // The beam moves one 35 ns step on every other clock.
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            hpos_out <= 11'h000;
            vpos_out <= 11'h000;
            tick_out <= 1'b0;
        end else begin
            tick_out <= ~tick_out;
            if (tick_out && hpos_out == 11'(HMAX - 1)) begin
                hpos_out <= 11'h000;
                if (vpos_out == 11'(VMAX - 1)) begin
                    vpos_out <= 11'h000;
                end else begin
                    vpos_out <= vpos_out + 11'h001;
                end
            end else if (tick_out) begin
                hpos_out <= hpos_out + 11'h001;
            end
        end
    end
endmodule

// ==== bench/tb_top.sv ====
// Testbench for the sprite channel: register access and frame measurements.
`timescale 1ns/1ps
module tb_top;
    import spc_pkg::*;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    localparam int HMAX  = 160;
    localparam int VMAX  = 6;
    localparam int FRAME = HMAX * VMAX * 2;
    logic        clock_in   = 1'b0;
    logic        reset_n_in = 1'b0;
    logic [8:0]  addr       = 9'h000;
    logic [15:0] wdata      = 16'h0000;
    logic        wr         = 1'b0;
    logic        rd         = 1'b0;
    logic        super_high_resolution_mode      = 1'b0;
    logic [1:0]  partner    = 2'h0;
    logic [15:0] rdata;
    logic [10:0] hpos, vpos, h0;
    logic        tick, valid, attach, scan2;
    logic [1:0]  pair;
    logic [7:0]  index, idx;
    int          errors = 0, total_checks = 0, lines, span, run2, nvld;
    logic [1:0]  rt [5] = '{RES_35, RES_70, RES_140, RES_LEGACY, RES_LEGACY};
    int          tk [5] = '{1, 2, 4, 4, 2};
    logic [1:0]  wc [3] = '{WID_16, WID_32, 2'h2};

    always #5 clock_in = ~clock_in;

    spc_beam_model #(.HMAX(HMAX), .VMAX(VMAX)) beam_u (
        .clock_in(clock_in), .reset_n_in(reset_n_in),
        .hpos_out(hpos), .vpos_out(vpos), .tick_out(tick));

    spc_channel dut_u (
        .clock_in(clock_in), .reset_n_in(reset_n_in), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
        .hpos_in(hpos), .vpos_in(vpos), .tick_in(tick),
        .high_resolution_mode_in(1'b0),
        .super_high_resolution_mode_in(super_high_resolution_mode),
        .partner_pair_in(partner), .pixel_pair_out(pair),
        .pixel_index_out(index), .pixel_valid_out(valid),
        .attach_out(attach), .scan_double_out(scan2));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [8:0] a, input logic [15:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock_in);
        wr <= 1'b0;
        @(posedge clock_in);
    endtask
    task automatic rd_chk(input logic [8:0] a, input logic [15:0] exp);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock_in);
        rd <= 1'b0;
        #1;
        check(rdata, exp);
        @(posedge clock_in);
    endtask
    function automatic logic [15:0] cfg(input logic [3:0] bank,
            input logic scan, input logic [1:0] wid, input logic [1:0] res);
        return {4'h0, bank, 3'h0, scan, wid, res};
    endfunction
    // Counts lines shown in one frame; times the first line's pixels.
    task automatic frame;
        int          c, first, rs, runs;
        logic [10:0] lv;
        logic [1:0]  prev;
        c = 0;
        while (!(vpos == 11'h000 && hpos == 11'h000) && c < FRAME) begin
            @(posedge clock_in);
            #1;
            c++;
        end
        lines = 0; lv = 11'h7FF; first = -1; runs = 0; rs = 0; prev = 2'h0;
        span = 0; run2 = 0; h0 = 11'h000; idx = 8'h00; nvld = 0;
        for (c = 0; c < FRAME; c++) begin
            @(posedge clock_in);
            #1;
            if (pair != 2'h0 && vpos != lv) begin
                lines++;
                lv = vpos;
            end
            if (lines == 1 && pair != 2'h0) begin
                if (first < 0) begin
                    first = c;
                    h0 = hpos;
                end
                span = c - first + 1;
            end
            if (lines == 1 && pair != prev) begin
                runs++;
                if (runs == 3) run2 = c - rs;
                rs = c;
            end
            if (runs == 2 && c == rs + 1) idx = index;
            prev = pair;
            if (valid) nvld++;
        end
    endtask
    task automatic go(input logic [10:0] hs, input logic [10:0] vs,
            input logic [10:0] ve, input logic attach_control, input logic [15:0] cw);
        wr_reg(OFS_CFG, cw);
        wr_reg(OFS_CTL, {ve[7:0], attach_control, vs[9], ve[9], hs[1], hs[0],
                         vs[8], ve[8], hs[2]});
        wr_reg(OFS_POS, {vs[7:0], hs[10:3]});
        repeat (4) begin
            wr_reg(OFS_BUF_LO, 16'h5555);
            wr_reg(OFS_BUF_HI, 16'h9999);
        end
        frame();
    endtask
    task automatic results;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        #1_000_000;
        errors++;
        results();
    end

    initial begin
        repeat (5) @(posedge clock_in);
        reset_n_in <= 1'b1;
        rd_chk(OFS_STATUS, 16'h0001);
        rd_chk(OFS_CFG, 16'h0000);
        rd_chk(9'h150, 16'h0000);
        wr_reg(OFS_CFG, 16'h0F1F);
        rd_chk(OFS_CFG, 16'h0F1F);
        wr_reg(OFS_CTL, 16'h0080);
        rd_chk(OFS_STATUS, 16'h0009);
        check({15'h0000, attach}, 16'h0001);
        rd_chk(OFS_CTL, 16'h0000);
        wr_reg(OFS_BUF_LO, 16'h1234);
        rd_chk(OFS_STATUS, 16'h000A);
        wr_reg(OFS_CTL, 16'h0000);
        rd_chk(OFS_STATUS, 16'h0001);
        go(11'h02D, 11'h001, 11'h003, 1'b0, cfg(4'h3, 1'b0, WID_16, RES_35));
        check(16'(lines), 16'h0002);
        // First pixel leaves the output register one clock after the start.
        check({5'h00, h0}, 16'h002E);
        check({8'h00, idx}, 16'h0031);
        check(16'(nvld), 16'h0030);
        wr_reg(OFS_CTL, 16'h0300);
        frame();
        check(16'(lines), 16'h0000);
        check(16'(nvld), 16'h0000);
        partner <= 2'h2;
        go(11'h02D, 11'h001, 11'h003, 1'b1, cfg(4'hA, 1'b0, WID_16, RES_35));
        check({8'h00, idx}, 16'h00A6);
        check(16'(nvld), 16'h0040);
        go(11'h02D, 11'h001, 11'h103, 1'b0, cfg(4'h0, 1'b0, WID_16, RES_35));
        check(16'(lines), 16'h0005);
        go(11'h02D, 11'h001, 11'h203, 1'b0, cfg(4'h0, 1'b0, WID_16, RES_35));
        check(16'(lines), 16'h0005);
        go(11'h02D, 11'h201, 11'h203, 1'b0, cfg(4'h0, 1'b0, WID_16, RES_35));
        check(16'(lines), 16'h0000);
        go(11'h42D, 11'h001, 11'h003, 1'b0, cfg(4'h0, 1'b0, WID_16, RES_35));
        check(16'(lines), 16'h0000);
        go(11'h42D, 11'h001, 11'h003, 1'b0, cfg(4'h0, 1'b1, WID_16, RES_35));
        check({5'h00, h0}, 16'h002E);
        check({15'h0000, scan2}, 16'h0001);
        for (int i = 0; i < 5; i++) begin
            super_high_resolution_mode <= (i == 4);
            go(11'h02D, 11'h001, 11'h003, 1'b0,
               cfg(4'h0, 1'b0, WID_16, rt[i]));
            check(16'(span), 16'(32 * tk[i]));
            check(16'(run2), 16'(2 * tk[i]));
        end
        super_high_resolution_mode <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            go(11'h02D, 11'h001, 11'h003, 1'b0,
               cfg(4'h0, 1'b0, wc[i], RES_35));
            check(16'(span), 16'(32 << i));
        end
        results();
    end
endmodule
